// ### rtl/ssq_pkg.sv
// Package of timing constants and state types for the supply sequencer.
`default_nettype none
package ssq_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS     = 5000;
	localparam int POR_DELAY_US      = 5000;  // Least power-on reset delay.
	localparam int FAULT_OFF_US      = 1000;  // Least fault-off hold.
	localparam int PWRUP_DELAY_US    = 1000;  // Least input presence time.
	localparam int SNS_RETRY_US      = 5000;  // Least sensor retry hold.
	localparam int SS_STEP_US        = 400;   // Soft-start dwell per step.
	localparam int POR_CYC       = (POR_DELAY_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAULT_OFF_CYC = (FAULT_OFF_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PWRUP_CYC     = (PWRUP_DELAY_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SNS_RETRY_CYC = (SNS_RETRY_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SS_STEP_CYC   = (SS_STEP_US * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ------------------------------------------------------------
	// Soft-start target
	// ------------------------------------------------------------
	localparam int        SS_STEPS   = 16;
	localparam logic [4:0] SS_HALF    = 5'h10;   // Half of full scale.
	localparam logic [4:0] SS_FULL    = 5'h1f;   // Nominal code reached after the 16 steps.
	localparam int        TMR_W      = 24;
	localparam int        N_SNS      = 2;
	// ------------------------------------------------------------
	// Main sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SSQ_STANDBY,
		SSQ_QUALIFY,
		SSQ_SOFTSTART,
		SSQ_POR,
		SSQ_RUN,
		SSQ_FAULT_OFF
	} ssq_state_e;
endpackage
`default_nettype wire

// ### rtl/ssq_sequencer.sv
// Supply sequencer and supervisor: start-up, soft-start, faults, reset and standby.
`timescale 1ns/100ps
`default_nettype none
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int POR_CYCLES   = POR_CYC,
	parameter int FAULT_CYCLES = FAULT_OFF_CYC,
	parameter int PWRUP_CYCLES = PWRUP_CYC,
	parameter int RETRY_CYCLES = SNS_RETRY_CYC,
	parameter int STEP_CYCLES  = SS_STEP_CYC
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Enable pins from the host
	input  wire logic             main_enable,
	input  wire logic             sensor_supply_enable,
	// Supply presence comparators
	input  wire logic             battery_input_ok,
	input  wire logic             keepalive_battery_input_ok,
	// Output window comparators
	input  wire logic             main_buck_output_ok,
	input  wire logic             low_volt_linear_output_ok,
	input  wire logic             keepalive_output_ok,
	input  wire logic [N_SNS-1:0] sensor_fault,
	// Regulator controls
	output logic                  buck_gate_enable,
	output logic [4:0]            buck_target,
	output logic                  main_buck_output_discharge,
	output logic                  low_volt_linear_enable,
	output logic                  low_volt_linear_output_discharge,
	output logic                  sensor_supply_one_enable,
	output logic                  sensor_supply_two_enable,
	output logic                  standby_active,
	// Open-drain supervisory outputs
	output logic                  power_good_out_o,
	output logic                  power_good_out_oe,
	output logic                  keepalive_good_out_o,
	output logic                  keepalive_good_out_oe
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic             en_s, sns_en_s, buck_ok_s, lin_ok_s, kam_ok_s;
	logic [N_SNS-1:0] sfault_s;
	logic             vin_done, kain_done, qual_run;
	logic [2:0]       en_sy_q, sns_sy_q, bok_sy_q, lok_sy_q, kok_sy_q;
	logic [2:0]       sf_sy_q [N_SNS];

	// Three stages; the level moves once stages two and three agree.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			en_sy_q  <= 3'h0;
			sns_sy_q <= 3'h0;
			bok_sy_q <= 3'h0;
			lok_sy_q <= 3'h0;
			kok_sy_q <= 3'h0;
			en_s      <= 1'b0;
			sns_en_s  <= 1'b0;
			buck_ok_s <= 1'b0;
			lin_ok_s  <= 1'b0;
			kam_ok_s  <= 1'b0;
		end else begin
			en_sy_q  <= {en_sy_q[1:0], main_enable};
			sns_sy_q <= {sns_sy_q[1:0], sensor_supply_enable};
			bok_sy_q <= {bok_sy_q[1:0], main_buck_output_ok};
			lok_sy_q <= {lok_sy_q[1:0], low_volt_linear_output_ok};
			kok_sy_q <= {kok_sy_q[1:0], keepalive_output_ok};
			if (en_sy_q[2] == en_sy_q[1])   en_s      <= en_sy_q[2];
			if (sns_sy_q[2] == sns_sy_q[1]) sns_en_s  <= sns_sy_q[2];
			if (bok_sy_q[2] == bok_sy_q[1]) buck_ok_s <= bok_sy_q[2];
			if (lok_sy_q[2] == lok_sy_q[1]) lin_ok_s  <= lok_sy_q[2];
			if (kok_sy_q[2] == kok_sy_q[1]) kam_ok_s  <= kok_sy_q[2];
		end
	end

	// Input presence qualifiers, one per supply input.
	ssq_sync_timer #(.LIMIT(PWRUP_CYCLES)) u_vin_qual (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.raw_in   (battery_input_ok),
		.run      (qual_run),
		.level_q  (),
		.done_q   (vin_done)
	);
	ssq_sync_timer #(.LIMIT(PWRUP_CYCLES)) u_kain_qual (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.raw_in   (keepalive_battery_input_ok),
		.run      (qual_run),
		.level_q  (),
		.done_q   (kain_done)
	);

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	ssq_state_e       state_q;
	logic [TMR_W-1:0] tmr_q;
	logic [4:0]       step_q;
	logic             outs_ok;

	assign outs_ok  = buck_ok_s && lin_ok_s;
	assign qual_run = (state_q == SSQ_QUALIFY);

	// Enable low beats every other state so standby is always reachable.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= SSQ_STANDBY;
			tmr_q   <= '0;
			step_q  <= 5'h0;
		end else if (!en_s) begin
			state_q <= SSQ_STANDBY;
			tmr_q   <= '0;
			step_q  <= 5'h0;
		end else begin
			unique case (state_q)
				SSQ_STANDBY: begin
					state_q <= SSQ_QUALIFY;
				end
				SSQ_QUALIFY: begin
					if (vin_done && kain_done) begin
						state_q <= SSQ_SOFTSTART;
						step_q  <= 5'h0;
						tmr_q   <= '0;
					end
				end
				SSQ_SOFTSTART: begin
					if (tmr_q >= TMR_W'(STEP_CYCLES - 1)) begin
						tmr_q <= '0;
						if (step_q == 5'(SS_STEPS)) begin
							// Soft-start over: check both outputs.
							if (outs_ok) begin
								state_q <= SSQ_POR;
							end else begin
								state_q <= SSQ_FAULT_OFF;
							end
						end else begin
							step_q <= step_q + 5'h1;
						end
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				SSQ_POR: begin
					if (!outs_ok) begin
						state_q <= SSQ_FAULT_OFF;
						tmr_q   <= '0;
					end else if (tmr_q >= TMR_W'(POR_CYCLES - 1)) begin
						state_q <= SSQ_RUN;
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				SSQ_RUN: begin
					if (!outs_ok) begin
						state_q <= SSQ_FAULT_OFF;
						tmr_q   <= '0;
					end
				end
				SSQ_FAULT_OFF: begin
					if (tmr_q >= TMR_W'(FAULT_CYCLES - 1)) begin
						state_q <= SSQ_SOFTSTART;
						tmr_q   <= '0;
						step_q  <= 5'h0;
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Regulator controls
	// ------------------------------------------------------------
	logic buck_on;
	assign buck_on = (state_q == SSQ_SOFTSTART) || (state_q == SSQ_POR) ||
		(state_q == SSQ_RUN);

	// Linear regulator shares the switcher's on, off and discharge.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			buck_gate_enable                 <= 1'b0;
			buck_target                      <= 5'h0;
			low_volt_linear_enable           <= 1'b0;
			main_buck_output_discharge       <= 1'b1;
			low_volt_linear_output_discharge <= 1'b1;
			standby_active                   <= 1'b1;
		end else begin
			buck_gate_enable                 <= buck_on;
			buck_target                      <= buck_on ? (SS_HALF - 5'h1 + step_q) : 5'h0;
			low_volt_linear_enable           <= buck_on;
			main_buck_output_discharge       <= (state_q == SSQ_STANDBY);
			low_volt_linear_output_discharge <= (state_q == SSQ_STANDBY);
			standby_active                   <= (state_q == SSQ_STANDBY);
		end
	end

	// ------------------------------------------------------------
	// Sensor supplies with retry timers
	// ------------------------------------------------------------
	logic [N_SNS-1:0] sns_on_q;

	for (genvar i = 0; i < N_SNS; i++) begin : g_sns
		logic [TMR_W-1:0] rt_q;
		logic             off_q;

		always_ff @(posedge core_clk) begin
			if (sys_rst) begin
				sf_sy_q[i]  <= 3'h0;
				sfault_s[i] <= 1'b0;
			end else begin
				sf_sy_q[i] <= {sf_sy_q[i][1:0], sensor_fault[i]};
				if (sf_sy_q[i][2] == sf_sy_q[i][1]) sfault_s[i] <= sf_sy_q[i][2];
			end
		end

		// A fault parks only this output until the retry count runs out.
		always_ff @(posedge core_clk) begin
			if (sys_rst || !sns_en_s || !buck_on) begin
				off_q       <= 1'b0;
				rt_q        <= '0;
				sns_on_q[i] <= 1'b0;
			end else if (off_q) begin
				sns_on_q[i] <= 1'b0;
				if (rt_q >= TMR_W'(RETRY_CYCLES - 1)) begin
					off_q <= 1'b0;
					rt_q  <= '0;
				end else begin
					rt_q <= rt_q + 1'b1;
				end
			end else if (sfault_s[i] && sns_on_q[i]) begin
				off_q       <= 1'b1;
				sns_on_q[i] <= 1'b0;
			end else begin
				sns_on_q[i] <= 1'b1;
			end
		end
	end

	assign sensor_supply_one_enable = sns_on_q[0];
	assign sensor_supply_two_enable = sns_on_q[1];

	// ------------------------------------------------------------
	// Open-drain supervisory outputs
	// ------------------------------------------------------------
	// The output value is always low; only the enable moves.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			power_good_out_o      <= 1'b0;
			power_good_out_oe     <= 1'b1;
			keepalive_good_out_o  <= 1'b0;
			keepalive_good_out_oe <= 1'b1;
		end else begin
			power_good_out_oe     <= !((state_q == SSQ_RUN) && outs_ok);
			keepalive_good_out_oe <= !kam_ok_s;
		end
	end
endmodule
`default_nettype wire

// ### rtl/ssq_sync_timer.sv
// Three-stage input synchroniser followed by a qualify timer.
`timescale 1ns/100ps
`default_nettype none
module ssq_sync_timer
	import ssq_pkg::*;
#(
	parameter int LIMIT = 1
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Raw level and qualify control
	input  wire logic raw_in,
	input  wire logic run,
	// Results
	output logic      level_q,
	output logic      done_q
);
	logic [2:0]       sync_q;
	logic [TMR_W-1:0] cnt_q;

	// Stage one feeds only stage two; a change counts once two and three agree.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync_q  <= 3'h0;
			level_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[1:0], raw_in};
			if (sync_q[2] == sync_q[1]) begin
				level_q <= sync_q[2];
			end
		end
	end

	// Continuous presence is needed; a drop of two cycles or more restarts the count.
	always_ff @(posedge core_clk) begin
		if (sys_rst || !run || !level_q) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (cnt_q >= TMR_W'(LIMIT - 1)) begin
			done_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verif/ssq_host_model.sv
// Host processor model: drives the enable pins and reads power-good.
`timescale 1ns/100ps
`default_nettype none
module ssq_host_model (
	// Clock
	input  wire logic core_clk,
	// Enable pins
	output var logic  main_enable,
	output var logic  sensor_supply_enable,
	// Open-drain power-good with board pull-up
	input  wire logic power_good_out_o,
	input  wire logic power_good_out_oe,
	output wire logic power_good
);
	// The pull-up wins whenever the device lets go of the pin.
	assign power_good = power_good_out_oe ? power_good_out_o : 1'b1;
	initial begin
		main_enable = 1'b0;
		sensor_supply_enable = 1'b0;
	end
	// Pins change just after an edge, as firmware writing a port would.
	task automatic set_pins(input logic main_en, input logic sens_en);
		@(posedge core_clk);
		#1;
		main_enable = main_en;
		sensor_supply_enable = sens_en;
	endtask
endmodule
`default_nettype wire

// ### verif/ssq_sequencer_sva.sv
// Port checker for the supply sequencer.
`timescale 1ns/100ps
`default_nettype none
module ssq_sequencer_sva
	import ssq_pkg::*;
#(
	parameter int POR_CYCLES   = 20,
	parameter int FAULT_CYCLES = 12,
	parameter int PWRUP_CYCLES = 10,
	parameter int STEP_CYCLES  = 4
) (
	// Clock, reset and inputs
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       main_enable,
	input wire logic       sensor_supply_enable,
	input wire logic       battery_input_ok,
	input wire logic       keepalive_battery_input_ok,
	input wire logic       main_buck_output_ok,
	input wire logic       low_volt_linear_output_ok,
	input wire logic       keepalive_output_ok,
	// Outputs
	input wire logic       buck_gate_enable,
	input wire logic [4:0] buck_target,
	input wire logic       main_buck_output_discharge,
	input wire logic       low_volt_linear_output_discharge,
	input wire logic       low_volt_linear_enable,
	input wire logic       sensor_supply_one_enable,
	input wire logic       sensor_supply_two_enable,
	input wire logic       standby_active,
	input wire logic       power_good_out_oe,
	input wire logic       keepalive_good_out_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic [31:0] sup_q;
	logic [31:0] on_q;
	logic [31:0] off_q;
	// Run lengths of supplies present, switcher on and off; they saturate so long runs stay sane.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sup_q <= 32'h0;
			on_q  <= 32'h0;
			off_q <= 32'h0;
		end else begin
			sup_q <= (battery_input_ok && keepalive_battery_input_ok) ?
				sup_q + {31'h0, ~&sup_q} : 32'h0;
			on_q  <= buck_gate_enable ? on_q + {31'h0, ~&on_q} : 32'h0;
			off_q <= buck_gate_enable ? 32'h0 : off_q + {31'h0, ~&off_q};
		end
	end
	a_standby_power_off:
	assert property (standby_active |-> !buck_gate_enable && !low_volt_linear_enable
		&& main_buck_output_discharge && low_volt_linear_output_discharge)
		else $error("switcher live in standby");
	a_standby_rest_off:
	assert property (standby_active |-> !sensor_supply_one_enable && !sensor_supply_two_enable
		&& power_good_out_oe) else $error("sensor or power-good live in standby");
	a_linear_follows_gate:
	assert property (low_volt_linear_enable == buck_gate_enable) else $error("linear not with switcher");
	a_target_single_step:
	assert property (buck_gate_enable && $past(buck_gate_enable) && buck_target != $past(buck_target)
		|-> buck_target == $past(buck_target) + 5'h01) else $error("target jumped");
	a_enable_low_standby:
	assert property (!main_enable [*8] |-> standby_active) else $error("no standby");
	a_sensor_enable_off:
	assert property (!sensor_supply_enable [*8] |-> !sensor_supply_one_enable
		&& !sensor_supply_two_enable) else $error("sensor on while disabled");
	a_keepalive_flag_low:
	assert property (!keepalive_output_ok [*8] |-> keepalive_good_out_oe) else $error("keep-alive flag");
	a_pgood_pulled_low:
	assert property ((!main_buck_output_ok || !low_volt_linear_output_ok) [*8] |-> power_good_out_oe)
		else $error("power-good not pulled low");
	a_pgood_release_time:
	assert property ($fell(power_good_out_oe) |-> main_buck_output_ok && low_volt_linear_output_ok
		&& on_q >= POR_CYCLES + (SS_STEPS + 1) * STEP_CYCLES) else $error("early power-good");
	a_gate_rise_qualified:
	assert property ($rose(buck_gate_enable) |-> sup_q >= PWRUP_CYCLES && off_q >= FAULT_CYCLES)
		else $error("switcher started early");
	c_pgood_release: cover property ($fell(power_good_out_oe));
	c_fault_off: cover property ($fell(buck_gate_enable) && !standby_active);
	c_standby_entry: cover property ($rose(standby_active));
endmodule
bind ssq_sequencer ssq_sequencer_sva #(.POR_CYCLES(POR_CYCLES), .FAULT_CYCLES(FAULT_CYCLES),
	.PWRUP_CYCLES(PWRUP_CYCLES), .STEP_CYCLES(STEP_CYCLES)) ssq_sequencer_sva_inst (
	.core_clk, .sys_rst, .main_enable, .sensor_supply_enable, .battery_input_ok,
	.keepalive_battery_input_ok, .main_buck_output_ok, .low_volt_linear_output_ok,
	.keepalive_output_ok, .buck_gate_enable, .buck_target, .main_buck_output_discharge,
	.low_volt_linear_output_discharge, .low_volt_linear_enable, .sensor_supply_one_enable,
	.sensor_supply_two_enable, .standby_active, .power_good_out_oe, .keepalive_good_out_oe);
`default_nettype wire

// ### verif/tb.sv
// Self-checking testbench of the supply sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("BAD %s exp %0h got %0h", w, e, g); end end
module tb
	import ssq_pkg::*;
;
	localparam int POR_N = 20, FAULT_N = 12, PWRUP_N = 10, RETRY_N = 24, STEP_N = 4;
	logic core_clk = 1'b0, sys_rst, main_enable, sensor_supply_enable, power_good;
	logic battery_input_ok, keepalive_battery_input_ok, main_buck_output_ok;
	logic low_volt_linear_output_ok, keepalive_output_ok, buck_gate_enable;
	logic main_buck_output_discharge, low_volt_linear_enable, low_volt_linear_output_discharge;
	logic sensor_supply_one_enable, sensor_supply_two_enable, standby_active;
	logic power_good_out_o, power_good_out_oe, keepalive_good_out_o, keepalive_good_out_oe;
	logic [N_SNS-1:0] sensor_fault;
	logic [4:0]       buck_target;
	int               fail_count = 0, tests_run = 0, cyc, steps;
	time              t0;
	always #2.5 core_clk = ~core_clk;
	ssq_sequencer #(.POR_CYCLES(POR_N), .FAULT_CYCLES(FAULT_N), .PWRUP_CYCLES(PWRUP_N),
		.RETRY_CYCLES(RETRY_N), .STEP_CYCLES(STEP_N)) ssq_sequencer_inst (.core_clk, .sys_rst,
		.main_enable, .sensor_supply_enable, .battery_input_ok, .keepalive_battery_input_ok,
		.main_buck_output_ok, .low_volt_linear_output_ok, .keepalive_output_ok, .sensor_fault,
		.buck_gate_enable, .buck_target, .main_buck_output_discharge, .low_volt_linear_enable,
		.low_volt_linear_output_discharge, .sensor_supply_one_enable, .sensor_supply_two_enable,
		.standby_active, .power_good_out_o, .power_good_out_oe, .keepalive_good_out_o,
		.keepalive_good_out_oe);
	ssq_host_model ssq_host_model_inst (.core_clk, .main_enable, .sensor_supply_enable,
		.power_good_out_o, .power_good_out_oe, .power_good);
	// --- Helpers ---
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	function automatic logic probe(input int sel);
		case (sel)
			0: return buck_gate_enable;
			1: return power_good;
			2: return sensor_supply_one_enable;
			default: return standby_active;
		endcase
	endfunction
	// Bounded poll of one output; cyc tells how long the wait took.
	task automatic wait_for(input int sel, input logic lvl, input int lim);
		cyc = 0;
		while (probe(sel) !== lvl && cyc < lim) begin
			tick(1);
			cyc++;
		end
		`CHK("wait", lvl, probe(sel))
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Watchdog sized well above the whole sequence.
	initial begin
		#30000;
		fail_count++;
		test_done();
	end
	initial begin
		{battery_input_ok, main_buck_output_ok, low_volt_linear_output_ok} = 3'h7;
		{keepalive_battery_input_ok, sensor_fault, keepalive_output_ok} = 4'h1;
		sys_rst = 1'b1;
		tick(3);
		sys_rst = 1'b0;
		`CHK("reset", 4'ha, {standby_active, buck_gate_enable, buck_target == 5'h00, power_good})
		ssq_host_model_inst.set_pins(1'b1, 1'b1);
		tick(40);
		`CHK("one supply", 1'b0, buck_gate_enable)
		keepalive_battery_input_ok = 1'b1;
		tick(5);
		keepalive_battery_input_ok = 1'b0;
		tick(20);
		`CHK("short presence", 1'b0, buck_gate_enable)
		keepalive_battery_input_ok = 1'b1;
		wait_for(0, 1'b1, 40);
		t0 = $time;
		`CHK("ss start", SS_FULL - 5'h10, buck_target)
		steps = 0;
		cyc = 0;
		// Count the codes the target climbs; a jump of several codes counts as several steps.
		while (buck_target !== SS_FULL && cyc < 40 * STEP_N) begin
			tick(1);
			cyc++;
			if (buck_target !== SS_FULL - 5'h10 + steps[4:0]) steps++;
		end
		`CHK("ss steps", SS_STEPS, steps)
		`CHK("ss dwell", SS_STEPS * STEP_N, cyc)
		wait_for(1, 1'b1, 200);
		`CHK("por span", 1'b1, $time - t0 >= 5 * (POR_N + (SS_STEPS + 1) * STEP_N))
		`CHK("sensors on", 2'h3, {sensor_supply_one_enable, sensor_supply_two_enable})
		sensor_fault = 2'h1;
		wait_for(2, 1'b0, 8);
		sensor_fault = 2'h0;
		`CHK("other sensor", 1'b1, sensor_supply_two_enable)
		wait_for(2, 1'b1, 100);
		`CHK("retry hold", 1'b1, cyc >= RETRY_N - 1)
		ssq_host_model_inst.set_pins(1'b1, 1'b0);
		tick(8);
		`CHK("sensors off", 2'h0, {sensor_supply_one_enable, sensor_supply_two_enable})
		ssq_host_model_inst.set_pins(1'b1, 1'b1);
		keepalive_output_ok = 1'b0;
		tick(8);
		`CHK("ka flag", 1'b1, keepalive_good_out_oe)
		`CHK("ka drive", 1'b0, keepalive_good_out_o)
		keepalive_output_ok = 1'b1;
		low_volt_linear_output_ok = 1'b0;
		wait_for(0, 1'b0, 10);
		`CHK("fault outs", 3'h0, {power_good, low_volt_linear_enable, sensor_supply_one_enable})
		wait_for(0, 1'b1, 40);
		`CHK("fault hold", 1'b1, cyc >= FAULT_N - 1)
		wait_for(0, 1'b0, 90);
		low_volt_linear_output_ok = 1'b1;
		wait_for(1, 1'b1, 300);
		ssq_host_model_inst.set_pins(1'b0, 1'b1);
		wait_for(3, 1'b1, 10);
		`CHK("standby", 6'h0c, {buck_gate_enable, low_volt_linear_enable, main_buck_output_discharge,
			low_volt_linear_output_discharge, sensor_supply_one_enable, power_good})
		`CHK("ka kept", 1'b0, keepalive_good_out_oe)
		// Stay in standby long enough for the enable-low property to see a full run.
		tick(8);
		`CHK("still standby", 1'b1, standby_active)
		ssq_host_model_inst.set_pins(1'b1, 1'b1);
		wait_for(3, 1'b0, 10);
		wait_for(0, 1'b1, 40);
		`CHK("requalify", 2'h2, {cyc >= PWRUP_N, power_good})
		wait_for(1, 1'b1, 300);
		test_done();
	end
endmodule
`default_nettype wire
